/* File: include/pmsc_defines.vh */
// Purpose: constants for the misc control and status register group
// Assumes: 12-bit register address, 8-bit data, one access per strobe
// Notes: Function
`ifndef PMSC_DEFINES_VH
`define PMSC_DEFINES_VH

`define PMSC_ADDR_PWRDN      12'h173
`define PMSC_ADDR_DIVRST     12'h177
`define PMSC_ADDR_LLCLR      12'h182
`define PMSC_ADDR_LOCKSTAT   12'h183
`define PMSC_ADDR_INSEL      12'h184
`define PMSC_ADDR_DACLO      12'h185
`define PMSC_ADDR_HOLD       12'h188
`define PMSC_ADDR_KEY        12'h555

`define PMSC_BIT_PRE_PD      6
`define PMSC_BIT_L2_PD       5
`define PMSC_BIT_FB_PD       4
`define PMSC_BIT_DIV_HOLD    5
`define PMSC_BIT_CLR_L1      1
`define PMSC_BIT_CLR_L2      0
`define PMSC_BIT_HOLDOVER    4

`define PMSC_PWRDN_RST       8'h60
`define PMSC_PWRDN_MASK      8'h70
`define PMSC_DIVRST_MASK     8'h20
`define PMSC_LLCLR_MASK      8'h03
`define PMSC_DAC_RST         10'h200

`endif

/* File: rtl/pmsc_regs.v */
// Purpose: misc power-down, divider hold, lock-lost and readback registers
// Assumes: serial port decoder gives one-cycle write and read strobes
// Notes: rd_data is registered, valid the cycle after rd_stb
`timescale 1ns/1ps
`include "pmsc_defines.vh"

module pmsc_regs (
  // clock and reset
  input  wire        ref_clk,
  input  wire        srst,
  // register port from serial decoder
  input  wire        wr_stb,
  input  wire        rd_stb,
  input  wire [11:0] addr,
  input  wire [7:0]  wr_data,
  output reg  [7:0]  rd_data,
  // live status from the loops
  input  wire        loop1_lock_level,
  input  wire        loop2_lock_level,
  input  wire        ref_input0_selected,
  input  wire        ref_input1_selected,
  input  wire        ref_input2_selected,
  input  wire        ref_input0_signal_loss,
  input  wire        ref_input1_signal_loss,
  input  wire        holdover_indicator,
  input  wire        dac_valid,
  input  wire [9:0]  dac_value,
  // controls to the loops
  output reg         loop2_prescaler_powerdown,
  output reg         loop2_powerdown,
  output reg         ext_feedback_input_powerdown,
  output reg         loop1_ref_divider_hold,
  output reg         loop1_lock_lost_flag,
  output reg         loop2_lock_lost_flag
);

  // write-protect key; write-only, reads return zero
  reg  [7:0] key_r;
  reg  [7:0] key_nxt;
  // lock-lost clear controls
  reg        clr1_r;
  reg        clr1_nxt;
  reg        clr2_r;
  reg        clr2_nxt;
  // next values of the control outputs
  reg        pre_pd_nxt;
  reg        l2_pd_nxt;
  reg        fb_pd_nxt;
  reg        div_hold_nxt;
  // lock level of the previous edge, for fall detection
  reg        lock1_d_r;
  reg        lock2_d_r;
  // next values of the sticky lock-lost flags
  reg        lost1_nxt;
  reg        lost2_nxt;
  // dac readback copy
  reg  [9:0] dac_r;
  reg  [9:0] dac_nxt;
  // read path: selected byte and next registered read data
  reg  [7:0] rd_nxt;
  reg  [7:0] rd_data_nxt;
  // register decode
  wire       hit_pwrdn;
  wire       hit_divrst;
  wire       hit_llclr;
  wire       hit_lockstat;
  wire       hit_insel;
  wire       hit_daclo;
  wire       hit_hold;
  wire       hit_key;
  // qualified write strobes
  wire       unlocked;
  wire       wr_ok;
  wire       wr_pwrdn;
  wire       wr_divrst;
  wire       wr_llclr;
  wire       wr_key;
  // lock falls seen this edge
  wire       fall1;
  wire       fall2;

  // true when the port address names the given register
  function addr_is;
    input [11:0] a;
    input [11:0] offset;
    begin
      addr_is = (a == offset);
    end
  endfunction

  // true when a lock level was high last edge and is low now
  function falling;
    input prev;
    input cur;
    begin
      falling = prev & ~cur;
    end
  endfunction

  // sticky flag step: a held clear forces 0, a fall sets, else hold
  function lost_next;
    input flag;
    input clear;
    input fall;
    begin
      if (clear) begin
        lost_next = 1'h0;
      end else if (fall) begin
        lost_next = 1'h1;
      end else begin
        lost_next = flag;
      end
    end
  endfunction

  // keeps the defined bits of a byte; reserved bits go to zero
  function [7:0] keep_bits;
    input [7:0] data;
    input [7:0] mask;
    begin
      keep_bits = data & mask;
    end
  endfunction

  // one compare per register offset
  assign hit_pwrdn    = addr_is(addr, `PMSC_ADDR_PWRDN);
  assign hit_divrst   = addr_is(addr, `PMSC_ADDR_DIVRST);
  assign hit_llclr    = addr_is(addr, `PMSC_ADDR_LLCLR);
  assign hit_lockstat = addr_is(addr, `PMSC_ADDR_LOCKSTAT);
  assign hit_insel    = addr_is(addr, `PMSC_ADDR_INSEL);
  assign hit_daclo    = addr_is(addr, `PMSC_ADDR_DACLO);
  assign hit_hold     = addr_is(addr, `PMSC_ADDR_HOLD);
  assign hit_key      = addr_is(addr, `PMSC_ADDR_KEY);

  // writes land only while unlocked, except to the key itself
  assign unlocked  = (key_r == 8'h00);
  assign wr_ok     = wr_stb & (unlocked | hit_key);
  assign wr_pwrdn  = wr_ok & hit_pwrdn;
  assign wr_divrst = wr_ok & hit_divrst;
  assign wr_llclr  = wr_ok & hit_llclr;
  assign wr_key    = wr_ok & hit_key;

  // a detector window restart drops the level and shows up here as a fall
  assign fall1 = falling(lock1_d_r, loop1_lock_level);
  assign fall2 = falling(lock2_d_r, loop2_lock_level);

  // next values of the control registers; unwritten bits hold
  always @* begin
    pre_pd_nxt   = loop2_prescaler_powerdown;
    l2_pd_nxt    = loop2_powerdown;
    fb_pd_nxt    = ext_feedback_input_powerdown;
    div_hold_nxt = loop1_ref_divider_hold;
    clr1_nxt     = clr1_r;
    clr2_nxt     = clr2_r;
    key_nxt      = key_r;
    if (wr_pwrdn) begin
      pre_pd_nxt = wr_data[`PMSC_BIT_PRE_PD];
      l2_pd_nxt  = wr_data[`PMSC_BIT_L2_PD];
      fb_pd_nxt  = wr_data[`PMSC_BIT_FB_PD];
    end else if (wr_divrst) begin
      div_hold_nxt = wr_data[`PMSC_BIT_DIV_HOLD];
    end else if (wr_llclr) begin
      clr1_nxt = wr_data[`PMSC_BIT_CLR_L1];
      clr2_nxt = wr_data[`PMSC_BIT_CLR_L2];
    end else if (wr_key) begin
      key_nxt = wr_data;
    end
  end

  // power-down controls; all three come up powered down
  always @(posedge ref_clk) begin
    if (srst) begin
      loop2_prescaler_powerdown    <= 1'h1;
      loop2_powerdown              <= 1'h1;
      ext_feedback_input_powerdown <= 1'h1;
    end else begin
      loop2_prescaler_powerdown    <= pre_pd_nxt;
      loop2_powerdown              <= l2_pd_nxt;
      ext_feedback_input_powerdown <= fb_pd_nxt;
    end
  end

  // divider hold; while set loop1 cannot lock
  always @(posedge ref_clk) begin
    if (srst) begin
      loop1_ref_divider_hold <= 1'h0;
    end else begin
      loop1_ref_divider_hold <= div_hold_nxt;
    end
  end

  // clear controls; host writes 1 then 0 to rearm a flag
  always @(posedge ref_clk) begin
    if (srst) begin
      clr1_r <= 1'h0;
      clr2_r <= 1'h0;
    end else begin
      clr1_r <= clr1_nxt;
      clr2_r <= clr2_nxt;
    end
  end

  // write-protect key; a nonzero value locks the other registers
  always @(posedge ref_clk) begin
    if (srst) begin
      key_r <= 8'h00;
    end else begin
      key_r <= key_nxt;
    end
  end

  // lock level history; reset low so no false fall follows reset
  always @(posedge ref_clk) begin
    if (srst) begin
      lock1_d_r <= 1'h0;
      lock2_d_r <= 1'h0;
    end else begin
      lock1_d_r <= loop1_lock_level;
      lock2_d_r <= loop2_lock_level;
    end
  end

  // flag next values; a held clear wins over a fall in the same cycle
  always @* begin
    lost1_nxt = lost_next(loop1_lock_lost_flag, clr1_r, fall1);
    lost2_nxt = lost_next(loop2_lock_lost_flag, clr2_r, fall2);
  end

  // sticky lock-lost flags
  always @(posedge ref_clk) begin
    if (srst) begin
      loop1_lock_lost_flag <= 1'h0;
      loop2_lock_lost_flag <= 1'h0;
    end else begin
      loop1_lock_lost_flag <= lost1_nxt;
      loop2_lock_lost_flag <= lost2_nxt;
    end
  end

  // dac copy takes a new value only when the dac loop offers one
  always @* begin
    dac_nxt = dac_r;
    if (dac_valid) begin
      dac_nxt = dac_value;
    end
  end

  // dac readback holds 512 from reset until the first update
  always @(posedge ref_clk) begin
    if (srst) begin
      dac_r <= `PMSC_DAC_RST;
    end else begin
      dac_r <= dac_nxt;
    end
  end

  // read mux; unmapped offsets, reserved bits and the key read zero
  always @* begin
    rd_nxt = 8'h00;
    if (hit_pwrdn) begin
      rd_nxt = keep_bits({1'h0, loop2_prescaler_powerdown, loop2_powerdown,
                          ext_feedback_input_powerdown, 4'h0},
                         `PMSC_PWRDN_MASK);
    end else if (hit_divrst) begin
      rd_nxt = keep_bits({2'h0, loop1_ref_divider_hold, 5'h00},
                         `PMSC_DIVRST_MASK);
    end else if (hit_llclr) begin
      rd_nxt = keep_bits({6'h00, clr1_r, clr2_r}, `PMSC_LLCLR_MASK);
    end else if (hit_lockstat) begin
      rd_nxt = {4'h0,
                loop1_lock_lost_flag,
                loop1_lock_level,
                loop2_lock_lost_flag,
                loop2_lock_level};
    end else if (hit_insel) begin
      rd_nxt = {dac_r[9:8],
                ref_input2_selected,
                ref_input1_selected,
                ref_input0_selected,
                1'h0,
                ref_input1_signal_loss,
                ref_input0_signal_loss};
    end else if (hit_daclo) begin
      rd_nxt = dac_r[7:0];
    end else if (hit_hold) begin
      rd_nxt = {3'h0, holdover_indicator, 4'h0};
    end else if (hit_key) begin
      rd_nxt = 8'h00;
    end
  end

  // read data changes only on a read strobe and holds otherwise
  always @* begin
    rd_data_nxt = rd_data;
    if (rd_stb) begin
      rd_data_nxt = rd_nxt;
    end
  end

  // registered read data
  always @(posedge ref_clk) begin
    if (srst) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= rd_data_nxt;
    end
  end

endmodule

/* File: dv/pmsc_chk.sv */
// Purpose: assertions on misc control and status regs
// Assumes: rd_data valid the cycle after rd_stb
// Notes: bound to pmsc_regs below
`timescale 1ns/1ps
module pmsc_chk(
  input wire        ref_clk, srst, wr_stb, rd_stb, loop1_lock_level, loop2_lock_level,
  input wire        holdover_indicator, loop2_powerdown, loop1_ref_divider_hold,
  input wire        loop1_lock_lost_flag, loop2_lock_lost_flag,
  input wire [11:0] addr,
  input wire [7:0]  rd_data);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // controls move only on reset or a write
  a_pd_reset: assert property (disable iff (1'h0) srst |=> loop2_powerdown)
    else $error("pd reset");
  a_pd_cause: assert property ($changed(loop2_powerdown) |->
    $past(srst) || $past(wr_stb && addr == 12'h173)) else $error("pd change");
  a_hold_cause: assert property ($changed(loop1_ref_divider_hold) |->
    $past(srst) || $past(wr_stb && addr == 12'h177)) else $error("hold change");
  // sticky flags rise only after a lock fall
  a_lost1_set: assert property ($rose(loop1_lock_lost_flag) |->
    $past(loop1_lock_level, 2) && !$past(loop1_lock_level)) else $error("lost1");
  a_lost2_set: assert property ($rose(loop2_lock_lost_flag) |->
    $past(loop2_lock_level, 2) && !$past(loop2_lock_level)) else $error("lost2");
  // readback contents
  a_lock_rd: assert property (rd_stb && addr == 12'h183 |=> rd_data[7:4] == 4'h0
    && rd_data[2] == $past(loop1_lock_level) && rd_data[0] == $past(loop2_lock_level))
    else $error("lock rd");
  a_key_rd: assert property (rd_stb && addr == 12'h555 |=> rd_data == 8'h00)
    else $error("key rd");
  a_hold_rd: assert property (rd_stb && addr == 12'h188 |=>
    rd_data == {3'h0, $past(holdover_indicator), 4'h0}) else $error("hold rd");
endmodule
bind pmsc_regs pmsc_chk pmsc_chk_inst(.*);

/* File: dv/pmsc_host.sv */
// Purpose: host side of the register port
// Assumes: one-cycle strobes, read data the cycle after
// Notes: idle lines show the inverse of the last value
`timescale 1ns/1ps
module pmsc_host(
  input wire        ref_clk,
  output reg        wr_stb = 1'h0, rd_stb = 1'h0,
  output reg [11:0] addr = 12'h0,
  output reg [7:0]  wr_data = 8'h0,
  input wire [7:0]  rd_data);
  // one write strobe, then lines released
  task wr(input [11:0] a, input [7:0] d);
    begin
      @(posedge ref_clk);
      {wr_stb, addr, wr_data} <= {1'h1, a, d};
      @(posedge ref_clk);
      {wr_stb, addr, wr_data} <= {1'h0, ~a, ~d};
      #1;
    end
  endtask
  // one read strobe, data taken after the next edge
  task rd(input [11:0] a, output [7:0] d);
    begin
      @(posedge ref_clk);
      {rd_stb, addr} <= {1'h1, a};
      @(posedge ref_clk);
      {rd_stb, addr} <= {1'h0, ~a};
      #1 d = rd_data;
    end
  endtask
endmodule

/* File: dv/testbench.sv */
// Purpose: directed test of misc control and status regs
// Assumes: host model drives the register port
// Notes: status inputs are set by hand
`timescale 1ns/1ps
module testbench;
  reg ref_clk = 1'h0, srst = 1'h1, loop1_lock_level = 1'h0, loop2_lock_level = 1'h0;
  reg holdover_indicator = 1'h0, dac_valid = 1'h0;
  reg [4:0] sel = 5'h0;
  reg [9:0] dac_value = 10'h0;
  wire wr_stb, rd_stb, loop2_powerdown, loop1_ref_divider_hold, pre_pd, fb_pd;
  wire loop1_lock_lost_flag, loop2_lock_lost_flag;
  wire [11:0] addr;
  wire [7:0] wr_data, rd_data;
  integer failures = 0, compares = 0;
  initial forever #50 ref_clk = ~ref_clk;
  pmsc_host pmsc_host_inst(.*);
  pmsc_regs pmsc_regs_inst(.*, .ref_input0_selected(sel[2]), .ref_input1_selected(sel[3]),
    .ref_input2_selected(sel[4]), .ref_input0_signal_loss(sel[0]),
    .ref_input1_signal_loss(sel[1]), .loop2_prescaler_powerdown(pre_pd),
    .ext_feedback_input_powerdown(fb_pd));
  task cmp(input [7:0] g, input [7:0] e);
    begin
      compares = compares + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("Error at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task rc(input [11:0] a, input [7:0] e);
    reg [7:0] d;
    begin
      pmsc_host_inst.rd(a, d);
      cmp(d, e);
    end
  endtask
  task end_sim;
    begin
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  // directed sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    srst <= 1'h0;
    cmp({6'h0, pre_pd, loop2_powerdown}, 8'h03);
    pmsc_host_inst.wr(12'h173, 8'h8f);
    cmp({4'h0, pre_pd, loop2_powerdown, fb_pd, loop1_ref_divider_hold}, 8'h00);
    rc(12'h173, 8'h00);
    pmsc_host_inst.wr(12'h173, 8'h70);
    pmsc_host_inst.wr(12'h177, 8'hff);
    cmp({4'h0, pre_pd, loop2_powerdown, fb_pd, loop1_ref_divider_hold}, 8'h0f);
    rc(12'h177, 8'h20);
    pmsc_host_inst.wr(12'h177, 8'h00);
    rc(12'h185, 8'h00);
    @(posedge ref_clk) sel <= 5'h09;
    rc(12'h184, 8'h91);
    @(posedge ref_clk) {dac_valid, dac_value, sel} <= {1'h1, 10'h1a5, 5'h16};
    @(posedge ref_clk) dac_valid <= 1'h0;
    rc(12'h184, 8'h6a);
    rc(12'h185, 8'ha5);
    @(posedge ref_clk) {loop1_lock_level, loop2_lock_level} <= 2'h3;
    rc(12'h183, 8'h05);
    @(posedge ref_clk) loop1_lock_level <= 1'h0;
    @(posedge ref_clk);
    rc(12'h183, 8'h09);
    cmp({6'h0, loop1_lock_lost_flag, loop2_lock_lost_flag}, 8'h02);
    pmsc_host_inst.wr(12'h182, 8'hff);
    @(posedge ref_clk) loop2_lock_level <= 1'h0;
    rc(12'h183, 8'h00);
    rc(12'h182, 8'h03);
    pmsc_host_inst.wr(12'h182, 8'h00);
    rc(12'h183, 8'h00);
    @(posedge ref_clk) loop2_lock_level <= 1'h1;
    @(posedge ref_clk) loop2_lock_level <= 1'h0;
    @(posedge ref_clk);
    rc(12'h183, 8'h02);
    cmp({6'h0, loop1_lock_lost_flag, loop2_lock_lost_flag}, 8'h01);
    @(posedge ref_clk) holdover_indicator <= 1'h1;
    rc(12'h188, 8'h10);
    pmsc_host_inst.wr(12'h555, 8'hff);
    pmsc_host_inst.wr(12'h173, 8'h00);
    rc(12'h173, 8'h70);
    rc(12'h555, 8'h00);
    pmsc_host_inst.wr(12'h555, 8'h00);
    pmsc_host_inst.wr(12'h173, 8'h10);
    rc(12'h173, 8'h10);
    rc(12'h200, 8'h00);
    pmsc_host_inst.wr(12'h555, 8'h01);
    pmsc_host_inst.wr(12'h177, 8'h20);
    rc(12'h177, 8'h00);
    pmsc_host_inst.wr(12'h555, 8'h00);
    // mid-run reset restores power-on values
    @(posedge ref_clk) srst <= 1'h1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'h0;
    cmp({4'h0, pre_pd, loop2_powerdown, fb_pd, loop1_ref_divider_hold}, 8'h0e);
    cmp({6'h0, loop1_lock_lost_flag, loop2_lock_lost_flag}, 8'h00);
    rc(12'h184, 8'haa);
    rc(12'h185, 8'h00);
    end_sim;
  end
endmodule
